// File: logic/rtd_defines.svh
// constants for the register transfer decoder
`ifndef RTD_DEFINES_SVH
`define RTD_DEFINES_SVH
`define RTD_OP_TBL_HI         5'h04
`define RTD_OP_ACC_COL        10'h051
`define RTD_OP_CMP_LOAD       10'h239
`define RTD_OP_ACC_IRQ_CTRL1  10'h253
`define RTD_OP_ACC_WAKE0      10'h256
`define RTD_OP_ACC_WAKE1      10'h259
`define RTD_OP_ACC_WAKE2      10'h25A
`define RTD_OP_ACC_CONV_LOW   10'h249
`define RTD_OP_RAM_HI         6'h2C
`define RTD_OP_ACC_CLK_CTRL   10'h252
`define RTD_OP_ACC_CONV_CTRL  10'h244
`define RTD_OP_ACC_SP         10'h050
`define RTD_OP_ACC_IRQ_EN1    10'h054
`define RTD_OP_ACC_IRQ_EN2    10'h055
`define RTD_OP_ACC_TMR1       10'h24B
`define RTD_OP_ACC_TMR2       10'h24C
`define RTD_OP_ACC_TMR6       10'h250
`define RTD_OP_ACC_ROW        10'h052
`define RTD_OP_ACC_COL_IDX    10'h01F
`define RTD_OP_ACC_BANK       10'h053
`define RTD_OP_B_FROM_ACC     10'h00E
`define RTD_OP_COL_FROM_ACC   10'h029
`define RTD_OP_E_FROM_PAIR    10'h01A
`define RTD_OP_IRQ_CTRL1_WR   10'h217
`define RTD_MODE_BIT          3
`define RTD_RST_NIB           4'h0
`define RTD_RST_BYTE          8'h00
`define RTD_RST_COL           3'h0
`define RTD_RST_SP            3'h7
`define RTD_RST_ADDR          12'h000
`endif

// File: logic/rtd_pkg.sv
// types for the register transfer decoder
package rtd_pkg;
   typedef enum logic [1:0] {
      RTD_IDLE,
      RTD_FETCH,
      RTD_RETURN
   } rtd_state_type;
endpackage : rtd_pkg

// File: logic/rtd_top.sv
// register transfer decoder and executor of a 4-bit core
// Overview of operation
// - table read is 00100 plus five-bit page; one word, three cycles.
// - table read first increments stack pointer, saves pc at new level.
// - table address is page, then column pointer bits, then accumulator.
// - fetched word bits 7-4 go to b, bits 3-0 to accumulator.
// - after fetch pc restores from stack, pointer decrements, resume after.
// - column pointer read puts column bits in acc 2-0, bit 3 zero.
// - comparator load is a no-op unless mode bit set; then writes b,acc.
// - code 253 reads first interrupt control register into accumulator.
// - codes 256, 259, 25A read wakeup control registers zero, one, two.
// - low conversion read puts result bits 1,0 in acc 3,2; clears 1,0.
// - memory read loads acc from ram at pointer, then x xor immediate.
// - code 252 reads the clock control register into accumulator.
// - code 244 reads the converter control register into accumulator.
// - stack pointer read puts pointer in acc 2-0, bit 3 zero.
// - codes 054, 055 read first and second interrupt enable registers.
// - codes 24B, 24C, 250 read timer control registers one, two, six.
// - codes 052, 01F read row pointer x and column index y.
// - code 053 puts bank pointer bits in acc 1,0; clears 3,2.
// - code 00E copies accumulator into b, carry untouched.
// - column pointer load takes low three accumulator bits.
// - code 01A writes b into e high nibble, accumulator into low.
// - code 217 writes accumulator into first interrupt control register.
`timescale 1ns/1ns
`include "rtd_defines.svh"
module rtd_top
   import rtd_pkg::*;
(
   // clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        ce_i,
   // instruction issue
   input  wire logic        instr_valid_i,
   input  wire logic [9:0]  instr_i,
   input  wire logic [11:0] pc_i,
   output logic             busy_o,
   output logic             pc_load_o,
   output logic [11:0]      pc_o,
   output logic             pc_inc_o,
   output logic             skip_o,
   output logic             carry_we_o,
   // program memory read
   output logic [11:0]      rom_addr_o,
   input  wire logic [9:0]  rom_data_i,
   // ram read
   output logic [7:0]       ram_addr_o,
   input  wire logic [3:0]  ram_data_i,
   // peripheral registers read
   input  wire logic [3:0]  irq_ctrl_first_i,
   input  wire logic [3:0]  irq_enable_first_i,
   input  wire logic [3:0]  irq_enable_second_i,
   input  wire logic [3:0]  wakeup_ctrl_zero_i,
   input  wire logic [3:0]  wakeup_ctrl_one_i,
   input  wire logic [3:0]  wakeup_ctrl_two_i,
   input  wire logic [3:0]  timer_ctrl_one_i,
   input  wire logic [3:0]  timer_ctrl_two_i,
   input  wire logic [3:0]  timer_ctrl_six_i,
   input  wire logic [3:0]  clock_control_reg_i,
   input  wire logic [3:0]  converter_control_reg_i,
   input  wire logic [1:0]  conv_result_low_i,
   // peripheral register writes
   output logic             irq_ctrl_first_we_o,
   output logic             comparator_we_o,
   output logic [7:0]       comparator_data_o,
   // core registers
   output logic [3:0]       acc_o,
   output logic [3:0]       b_o,
   output logic [3:0]       x_o,
   output logic [3:0]       y_o,
   output logic [1:0]       z_o,
   output logic [2:0]       col_o,
   output logic [7:0]       e_o,
   output logic [2:0]       sp_o
);
   rtd_state_type st_q, st_d;
   logic [3:0]  acc_q, acc_d, b_q, b_d, x_q, x_d;
   logic [7:0]  e_q, e_d, cmp_q, cmp_d;
   logic [2:0]  col_q, col_d, sp_q, sp_d;
   logic [11:0] stk_q [0:7];
   logic [11:0] tbl_q, tbl_d;
   logic        stk_we;

   wire logic       go          = ce_i & instr_valid_i & (st_q == RTD_IDLE);
   wire logic       is_tbl_read = instr_i[9:5] == `RTD_OP_TBL_HI;
   wire logic       is_ram_read = instr_i[9:4] == `RTD_OP_RAM_HI;
   wire logic       mode_set = converter_control_reg_i[`RTD_MODE_BIT];
   wire logic [2:0] sp_inc   = sp_q + 3'h1;

   always_comb begin
      st_d      = st_q;
      acc_d     = acc_q;
      b_d       = b_q;
      x_d       = x_q;
      e_d       = e_q;
      cmp_d     = cmp_q;
      col_d     = col_q;
      sp_d      = sp_q;
      tbl_d     = tbl_q;
      stk_we    = 1'b0;
      pc_load_o = 1'b0;
      pc_o      = 12'h000;
      pc_inc_o  = 1'b0;
      irq_ctrl_first_we_o = 1'b0;
      comparator_we_o     = 1'b0;
      case (st_q)
         RTD_IDLE: begin
            if (go && is_tbl_read) begin
               sp_d   = sp_inc;
               stk_we = 1'b1;
               tbl_d  = {instr_i[4:0], col_q, acc_q};
               st_d   = RTD_FETCH;
            end else if (go) begin
               pc_inc_o = 1'b1;
               case (instr_i)
                  `RTD_OP_ACC_COL:       acc_d = {1'b0, col_q};
                  `RTD_OP_CMP_LOAD: begin
                     if (mode_set) begin
                        cmp_d           = {b_q, acc_q};
                        comparator_we_o = 1'b1;
                     end
                  end
                  `RTD_OP_ACC_IRQ_CTRL1: acc_d = irq_ctrl_first_i;
                  `RTD_OP_ACC_WAKE0:     acc_d = wakeup_ctrl_zero_i;
                  `RTD_OP_ACC_WAKE1:     acc_d = wakeup_ctrl_one_i;
                  `RTD_OP_ACC_WAKE2:     acc_d = wakeup_ctrl_two_i;
                  `RTD_OP_ACC_CONV_LOW:  acc_d = {conv_result_low_i, 2'b00};
                  `RTD_OP_ACC_CLK_CTRL:  acc_d = clock_control_reg_i;
                  `RTD_OP_ACC_CONV_CTRL: acc_d = converter_control_reg_i;
                  `RTD_OP_ACC_SP:        acc_d = {1'b0, sp_q};
                  `RTD_OP_ACC_IRQ_EN1:   acc_d = irq_enable_first_i;
                  `RTD_OP_ACC_IRQ_EN2:   acc_d = irq_enable_second_i;
                  `RTD_OP_ACC_TMR1:      acc_d = timer_ctrl_one_i;
                  `RTD_OP_ACC_TMR2:      acc_d = timer_ctrl_two_i;
                  `RTD_OP_ACC_TMR6:      acc_d = timer_ctrl_six_i;
                  `RTD_OP_ACC_ROW:       acc_d = x_q;
                  `RTD_OP_ACC_COL_IDX:   acc_d = y_o;
                  `RTD_OP_ACC_BANK:      acc_d = {2'b00, z_o};
                  `RTD_OP_B_FROM_ACC:    b_d   = acc_q;
                  `RTD_OP_COL_FROM_ACC:  col_d = acc_q[2:0];
                  `RTD_OP_E_FROM_PAIR:   e_d   = {b_q, acc_q};
                  `RTD_OP_IRQ_CTRL1_WR:  irq_ctrl_first_we_o = 1'b1;
                  default: begin
                     if (is_ram_read) begin
                        acc_d = ram_data_i;
                        x_d   = x_q ^ instr_i[3:0];
                     end
                  end
               endcase
            end
         end
         RTD_FETCH: begin
            if (ce_i) begin
               b_d   = rom_data_i[7:4];
               acc_d = rom_data_i[3:0];
               st_d  = RTD_RETURN;
            end
         end
         RTD_RETURN: begin
            if (ce_i) begin
               pc_load_o = 1'b1;
               pc_o      = stk_q[sp_q] + 12'h001;
               sp_d      = sp_q - 3'h1;
               st_d      = RTD_IDLE;
            end
         end
         default: st_d = RTD_IDLE;
      endcase
   end

   // y and z are owned elsewhere; only their reset values show here
   assign y_o = `RTD_RST_NIB;
   assign z_o = 2'b00;

   // ram address from row and column index
   assign ram_addr_o = {x_q, y_o};
   assign rom_addr_o = tbl_q;
   assign busy_o     = st_q != RTD_IDLE;
   assign skip_o     = 1'b0;
   assign carry_we_o = 1'b0;
   assign acc_o      = acc_q;
   assign b_o        = b_q;
   assign x_o        = x_q;
   assign e_o        = e_q;
   assign col_o      = col_q;
   assign sp_o       = sp_q;
   assign comparator_data_o = cmp_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q   <= RTD_IDLE;
         acc_q  <= `RTD_RST_NIB;
         b_q    <= `RTD_RST_NIB;
         x_q    <= `RTD_RST_NIB;
         e_q    <= `RTD_RST_BYTE;
         cmp_q  <= `RTD_RST_BYTE;
         col_q  <= `RTD_RST_COL;
         // pointer starts at the top so the first push lands on level zero
         sp_q   <= `RTD_RST_SP;
         tbl_q  <= `RTD_RST_ADDR;
      end else if (ce_i) begin
         st_q   <= st_d;
         acc_q  <= acc_d;
         b_q    <= b_d;
         x_q    <= x_d;
         e_q    <= e_d;
         cmp_q  <= cmp_d;
         col_q  <= col_d;
         sp_q   <= sp_d;
         tbl_q  <= tbl_d;
      end
   end

   // stack storage has no reset; a level is written before it is read
   always_ff @(posedge clk_i) begin
      if (ce_i && stk_we) begin
         stk_q[sp_inc] <= pc_i;
      end
   end

   // checks on register results look one edge after the word is taken; a frozen enable holds every register
   property p_tbl_three;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && is_tbl_read) |=> busy_o ##1 busy_o;
   endproperty
   a_tbl_three: assert property (p_tbl_three) else $error("table read too short");

   property p_sp_push;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && is_tbl_read) |=> sp_q == $past(sp_q) + 3'h1;
   endproperty
   a_sp_push: assert property (p_sp_push) else $error("stack pointer not pushed");

   property p_tbl_addr;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && is_tbl_read) |=> rom_addr_o == {$past(instr_i[4:0]), $past(col_q), $past(acc_q)};
   endproperty
   a_tbl_addr: assert property (p_tbl_addr) else $error("bad table address");

   property p_tbl_data;
      @(posedge clk_i) disable iff (!rst_b_i)
      (st_q == RTD_FETCH && ce_i) |=> {b_q, acc_q} == $past(rom_data_i[7:0]);
   endproperty
   a_tbl_data: assert property (p_tbl_data) else $error("table word split wrong");

   property p_return;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && is_tbl_read) |-> ##2 (pc_load_o || !ce_i);
   endproperty
   a_return: assert property (p_return) else $error("no return from table read");

   property p_sp_pop;
      @(posedge clk_i) disable iff (!rst_b_i)
      (st_q == RTD_RETURN && ce_i) |=> sp_q == $past(sp_q) - 3'h1;
   endproperty
   a_sp_pop: assert property (p_sp_pop) else $error("stack pointer not popped");

   property p_acc_col;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && instr_i == `RTD_OP_ACC_COL) |=> acc_q == {1'b0, $past(col_q)};
   endproperty
   a_acc_col: assert property (p_acc_col) else $error("column read wrong");

   property p_cmp_idle;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && instr_i == `RTD_OP_CMP_LOAD && !mode_set) |=> $stable(cmp_q);
   endproperty
   a_cmp_idle: assert property (p_cmp_idle) else $error("comparator written in wrong mode");

   property p_cmp_load;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && instr_i == `RTD_OP_CMP_LOAD && mode_set) |=>
         cmp_q == {$past(b_q), $past(acc_q)};
   endproperty
   a_cmp_load: assert property (p_cmp_load) else $error("comparator load wrong");

   property p_acc_irq;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && instr_i == `RTD_OP_ACC_IRQ_CTRL1) |=> acc_q == $past(irq_ctrl_first_i);
   endproperty
   a_acc_irq: assert property (p_acc_irq) else $error("interrupt control read wrong");

   property p_acc_conv_low;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && instr_i == `RTD_OP_ACC_CONV_LOW) |=> acc_q == {$past(conv_result_low_i), 2'b00};
   endproperty
   a_acc_conv_low: assert property (p_acc_conv_low) else $error("low result read wrong");

   property p_ram_xor;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && is_ram_read) |=> x_q == ($past(x_q) ^ $past(instr_i[3:0]))
         && acc_q == $past(ram_data_i);
   endproperty
   a_ram_xor: assert property (p_ram_xor) else $error("memory read wrong");

   property p_acc_conv_ctrl;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && instr_i == `RTD_OP_ACC_CONV_CTRL) |=> acc_q == $past(converter_control_reg_i);
   endproperty
   a_acc_conv_ctrl: assert property (p_acc_conv_ctrl) else $error("converter read wrong");

   property p_acc_sp;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && instr_i == `RTD_OP_ACC_SP) |=> acc_q == {1'b0, $past(sp_q)};
   endproperty
   a_acc_sp: assert property (p_acc_sp) else $error("stack pointer read wrong");

   property p_acc_row;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && instr_i == `RTD_OP_ACC_ROW) |=> acc_q == $past(x_q);
   endproperty
   a_acc_row: assert property (p_acc_row) else $error("row pointer read wrong");

   property p_acc_bank;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && instr_i == `RTD_OP_ACC_BANK) |=> acc_q == {2'b00, $past(z_o)};
   endproperty
   a_acc_bank: assert property (p_acc_bank) else $error("bank pointer read wrong");

   property p_b_from_acc;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && instr_i == `RTD_OP_B_FROM_ACC) |=> b_q == $past(acc_q);
   endproperty
   a_b_from_acc: assert property (p_b_from_acc) else $error("b load wrong");

   property p_col_from_acc;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && instr_i == `RTD_OP_COL_FROM_ACC) |=> col_q == $past(acc_q[2:0]);
   endproperty
   a_col_from_acc: assert property (p_col_from_acc) else $error("column load wrong");

   property p_e_pair;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && instr_i == `RTD_OP_E_FROM_PAIR) |=> e_q == {$past(b_q), $past(acc_q)};
   endproperty
   a_e_pair: assert property (p_e_pair) else $error("e load wrong");

   property p_irq_wr;
      @(posedge clk_i) disable iff (!rst_b_i)
      irq_ctrl_first_we_o == (go && instr_i == `RTD_OP_IRQ_CTRL1_WR);
   endproperty
   a_irq_wr: assert property (p_irq_wr) else $error("interrupt control write wrong");

   property p_single_step;
      @(posedge clk_i) disable iff (!rst_b_i)
      (go && !is_tbl_read) |-> pc_inc_o && !skip_o && !carry_we_o && !pc_load_o;
   endproperty
   a_single_step: assert property (p_single_step) else $error("single step wrong");

   c_tbl_read:  cover property (@(posedge clk_i) go && is_tbl_read);
   c_cmp_write: cover property (@(posedge clk_i) comparator_we_o);
   c_ram_read:  cover property (@(posedge clk_i) go && is_ram_read);
   c_refused:   cover property (@(posedge clk_i) busy_o && instr_valid_i);
endmodule : rtd_top

// File: tb/tb_rtd_top.sv
// self-checking bench for the register transfer decoder
`timescale 1ns/1ns
module tb_rtd_top;
   logic        clk_i, rst_b_i, ce_i, instr_valid_i;
   logic [9:0]  instr_i, rom_data_i, c;
   logic [11:0] pc_i, pc_o, rom_addr_o;
   logic        busy_o, pc_load_o, pc_inc_o, skip_o, carry_we_o;
   logic [7:0]  ram_addr_o, comparator_data_o, e_o, m_e, m_cmp;
   logic [3:0]  ram_data_i, irq_ctrl_first_i, irq_enable_first_i, irq_enable_second_i;
   logic [3:0]  wakeup_ctrl_zero_i, wakeup_ctrl_one_i, wakeup_ctrl_two_i;
   logic [3:0]  timer_ctrl_one_i, timer_ctrl_two_i, timer_ctrl_six_i;
   logic [3:0]  clock_control_reg_i, converter_control_reg_i, acc_o, b_o, x_o, y_o;
   logic [3:0]  m_acc, m_b, m_x;
   logic [1:0]  conv_result_low_i, z_o;
   logic [2:0]  col_o, sp_o, m_col, m_sp;
   logic        irq_ctrl_first_we_o, comparator_we_o, exp_iw, exp_cw, exp_inc;
   logic [63:0] r;
   int          fail_count = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   logic [9:0]  ops [23] = '{10'h051, 10'h239, 10'h253, 10'h256, 10'h259, 10'h25A, 10'h249,
      10'h2C0, 10'h252, 10'h244, 10'h050, 10'h054, 10'h055, 10'h24B, 10'h24C, 10'h250,
      10'h052, 10'h01F, 10'h053, 10'h00E, 10'h029, 10'h01A, 10'h217};

   rtd_top u_dut (.clk_i, .rst_b_i, .ce_i, .instr_valid_i, .instr_i, .pc_i, .busy_o, .pc_load_o,
      .pc_o, .pc_inc_o, .skip_o, .carry_we_o, .rom_addr_o, .rom_data_i, .ram_addr_o, .ram_data_i,
      .irq_ctrl_first_i, .irq_enable_first_i, .irq_enable_second_i, .wakeup_ctrl_zero_i,
      .wakeup_ctrl_one_i, .wakeup_ctrl_two_i, .timer_ctrl_one_i, .timer_ctrl_two_i,
      .timer_ctrl_six_i, .clock_control_reg_i, .converter_control_reg_i, .conv_result_low_i,
      .irq_ctrl_first_we_o, .comparator_we_o, .comparator_data_o, .acc_o, .b_o, .x_o, .y_o,
      .z_o, .col_o, .e_o, .sp_o);

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_val

   task automatic chk_bit(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : chk_bit

   task automatic rnd();
      r = {$urandom, $urandom};
      {irq_ctrl_first_i, irq_enable_first_i, irq_enable_second_i, wakeup_ctrl_zero_i,
       wakeup_ctrl_one_i, wakeup_ctrl_two_i, timer_ctrl_one_i, timer_ctrl_two_i,
       timer_ctrl_six_i, clock_control_reg_i, converter_control_reg_i} = r[43:0];
      {conv_result_low_i, ram_data_i, pc_i} = r[61:44];
   endtask : rnd

   task automatic model(input logic [9:0] op);
      exp_iw = 1'b0;
      exp_cw = 1'b0;
      exp_inc = 1'b1;
      case (op)
         10'h051: m_acc = {1'b0, m_col};
         10'h253: m_acc = irq_ctrl_first_i;
         10'h256: m_acc = wakeup_ctrl_zero_i;
         10'h259: m_acc = wakeup_ctrl_one_i;
         10'h25A: m_acc = wakeup_ctrl_two_i;
         10'h249: m_acc = {conv_result_low_i, 2'b00};
         10'h252: m_acc = clock_control_reg_i;
         10'h244: m_acc = converter_control_reg_i;
         10'h050: m_acc = {1'b0, m_sp};
         10'h054: m_acc = irq_enable_first_i;
         10'h055: m_acc = irq_enable_second_i;
         10'h24B: m_acc = timer_ctrl_one_i;
         10'h24C: m_acc = timer_ctrl_two_i;
         10'h250: m_acc = timer_ctrl_six_i;
         10'h052: m_acc = m_x;
         10'h01F, 10'h053: m_acc = 4'h0;
         10'h00E: m_b = m_acc;
         10'h01A: m_e = {m_b, m_acc};
         10'h029: m_col = m_acc[2:0];
         10'h217: exp_iw = 1'b1;
         10'h239: begin
            exp_cw = converter_control_reg_i[3];
            if (exp_cw) m_cmp = {m_b, m_acc};
         end
         default: begin
            if (op[9:4] == 6'h2C) begin
               m_acc = ram_data_i;
               m_x = m_x ^ op[3:0];
            end else if (op[9:5] == 5'h04) begin
               m_sp = m_sp + 3'h1;
               exp_inc = 1'b0;
            end
         end
      endcase
   endtask : model

   task automatic check_regs();
      chk_val(12'(acc_o), 12'(m_acc), "acc");
      chk_val(12'(b_o), 12'(m_b), "b");
      chk_val(12'(x_o), 12'(m_x), "x");
      chk_val(12'(e_o), 12'(m_e), "e");
      chk_val(12'(col_o), 12'(m_col), "col");
      chk_val(12'(sp_o), 12'(m_sp), "sp");
      chk_val(12'(comparator_data_o), 12'(m_cmp), "cmp");
      chk_val(12'({y_o, z_o}), 12'h000, "y z");
   endtask : check_regs

   task automatic issue(input logic [9:0] op, input int md);
      @(negedge clk_i);
      rnd();
      if (md >= 0) converter_control_reg_i[3] = md[0];
      instr_i = op;
      instr_valid_i = 1'b1;
      #1;
      chk_val(12'(ram_addr_o), 12'({m_x, 4'h0}), "ram addr");
      model(op);
      chk_bit(pc_inc_o, exp_inc, "pc inc");
      chk_bit(skip_o | carry_we_o, 1'b0, "skip carry");
      chk_bit(irq_ctrl_first_we_o, exp_iw, "irq wr");
      chk_bit(comparator_we_o, exp_cw, "cmp wr");
      @(posedge clk_i);
      #1;
      check_regs();
   endtask : issue

   // a transfer stays offered while busy, so a wrongly taken one shows up in b
   task automatic table_read(input logic [4:0] p);
      logic [2:0] sp0;
      logic [9:0] w;
      sp0 = m_sp;
      issue({5'h04, p}, -1);
      @(negedge clk_i);
      instr_i = 10'h00E;
      w = 10'($urandom);
      rom_data_i = w;
      #1;
      chk_val(rom_addr_o, {p, m_col, m_acc}, "table addr");
      chk_bit(busy_o, 1'b1, "busy");
      @(negedge clk_i);
      rom_data_i = ~w;
      #1;
      m_acc = w[3:0];
      m_b = w[7:4];
      check_regs();
      chk_bit(pc_load_o, 1'b1, "pc load");
      chk_val(pc_o, pc_i + 12'h001, "return pc");
      @(negedge clk_i);
      instr_valid_i = 1'b0;
      #1;
      m_sp = sp0;
      check_regs();
      chk_bit(busy_o | pc_load_o, 1'b0, "busy end");
   endtask : table_read

   // enable low must freeze every register and refuse the offered word
   task automatic stall(input logic [9:0] op);
      @(negedge clk_i);
      rnd();
      ce_i = 1'b0;
      instr_i = op;
      instr_valid_i = 1'b1;
      #1;
      chk_bit(pc_inc_o | irq_ctrl_first_we_o | comparator_we_o, 1'b0, "frozen strobe");
      @(posedge clk_i);
      #1;
      check_regs();
      chk_bit(busy_o, 1'b0, "frozen busy");
      @(negedge clk_i);
      ce_i = 1'b1;
      instr_valid_i = 1'b0;
   endtask : stall

   initial begin
      void'($urandom(91));
      {rst_b_i, instr_valid_i, instr_i, rom_data_i} = '0;
      ce_i = 1'b1;
      rnd();
      {m_acc, m_b, m_x, m_e, m_col, m_cmp} = '0;
      m_sp = 3'h7;
      repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      rst_b_i = 1'b1;
      check_regs();
      $display("test reset done");
      for (int k = 0; k < 23; k++) issue(ops[k], -1);
      $display("test every code done");
      issue(10'h239, 0);
      issue(10'h239, 1);
      issue(10'h2CF, -1);
      issue(10'h2C5, -1);
      table_read(5'h1F);
      table_read(5'h00);
      stall(10'h00E);
      stall(10'h217);
      stall(10'h088);
      $display("test corners done");
      repeat (200) begin
         c = ops[$urandom % 23];
         if (c == 10'h2C0) c[3:0] = 4'($urandom);
         issue(c, -1);
         if ($urandom % 8 == 0) table_read(5'($urandom));
         if ($urandom % 16 == 0) stall(ops[$urandom % 23]);
      end
      $display("test random done");
      @(negedge clk_i);
      instr_valid_i = 1'b0;
      end_of_test();
   end
endmodule : tb_rtd_top
